// [lsd_host_model.sv]
module lsd_host_model (
    input wire logic clk_in,
    input wire logic serial_out_in,
    output logic sclk_out,
    output logic sdata_out,
    output logic latch_out,
    output logic mode_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        latch_out = 1'b0;
        mode_out = 1'b0;
    end
    // MSB first, 200 ns clock that stands low between frames
    task automatic send(input logic [191:0] d, input int n, output logic [191:0] got);
        got = 192'h0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk_in);
            sdata_out <= d[i];
            repeat (3) @(posedge clk_in);
            sclk_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            got[i] = serial_out_in;
            sclk_out <= 1'b0;
        end
        @(posedge clk_in);
        sdata_out <= ~sdata_out;
    endtask
    task automatic pulse();
        @(posedge clk_in);
        latch_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        latch_out <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic set_mode(input logic m);
        @(posedge clk_in);
        mode_out <= m; // Latch held low across the change
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// [lsd_pkg.sv]
package lsd_pkg;

    typedef enum logic [2:0] {
        PH_BLANK = 3'b001,
        PH_RUN = 3'b010,
        PH_HOLD = 3'b100
    } lsd_phase_t;

    typedef logic [11:0] lsd_gs_t;

endpackage

// [lsd_regs.svh]
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH

// Register byte offsets on the Avalon-MM slave
`define LSD_OFS_CTRL 6'h00
`define LSD_OFS_STATUS 6'h04
`define LSD_OFS_PWM 6'h08
`define LSD_OFS_PINS 6'h0C

// Control register fields and reset value
`define LSD_CTRL_STEP_LSB 0
`define LSD_CTRL_STEP_W 3
`define LSD_CTRL_STEP_RST 3'h1

// Serial path sizes
`define LSD_STATUS_W 17
`define LSD_GS_BITS 192
`define LSD_DC_BITS 96
`define LSD_GS_W 12
`define LSD_DC_W 6
`define LSD_CHANNELS 16

// Pulse count at which open-LED data is taken, and counter ceiling
`define LSD_LOD_EDGE 12'h021
`define LSD_CNT_MAX 12'hFFF

// Synchroniser reset image: outputs-off pin reads high
`define LSD_PIN_W 23
`define LSD_PIN_RST 23'h000008

// Longest stagger delay line: three groups times largest step
`define LSD_DLY_LEN 21

`endif

// [lsd_status_out.sv]
// Behaviour
// - 17-bit status word, readable only in brightness mode
// - First serial rise after latch fall loads status
// - Status shifts out one bit per serial rise
// - Open flags update at 33rd reference rise, held
// - Only channels on at that edge are checked
// - Open flag 1 means open, 0 normal
// - Comparator below threshold sets channel open flag
// - Overtemp flag 1 when hot, 0 normal
// - Error output low when any flag set
// - Outputs-off high masks open flags from error
// - Error output valid only after first 33rd edge
// - Faulty channel switched off at 33rd falling edge
// - Overtemp indication sets flag, pulls error low
// - Overtemp flag clears at first serial fall only if cool
// - Four staggered channel groups on turn-on and turn-off
// - Outputs-off high: outputs off, counter reset
// - Short outputs-off low pulse truncates on-time
// - Serial out feeds next device serial in
// - Mode low 192-bit brightness, high 96-bit trim
// - Shift MSB first on serial rise, latch on rise
`include "lsd_regs.svh"

module lsd_status_out
    import lsd_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    input wire logic [5:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic SERIAL_CLK_IN,
    input wire logic LATCH_STROBE_IN,
    input wire logic SERIAL_IN,
    input wire logic MODE_IN,
    input wire logic OUTPUTS_OFF_IN,
    input wire logic PWM_REF_CLOCK_IN,
    input wire logic [15:0] OPEN_CMP_IN,
    input wire logic OVERTEMP_IN,
    output logic SERIAL_OUT,
    output logic [15:0] SINK_ON_OUT,
    output logic [95:0] CURRENT_TRIM_OUT,
    output logic ERROR_OUT_N_OUT,
    output logic ERROR_OE_OUT
);

    logic [`LSD_PIN_W-1:0] pin_s1;
    logic [`LSD_PIN_W-1:0] pin_s2;
    logic [`LSD_PIN_W-1:0] pin_d;
    logic sclk_rise;
    logic sclk_fall;
    logic lat_rise;
    logic lat_fall;
    logic pclk_rise;
    logic pclk_fall;
    logic mode;
    logic blank;
    logic serial_in;
    logic overtemp;
    logic [15:0] cmp_low;

    logic [`LSD_GS_BITS-1:0] shift_reg;
    logic [`LSD_GS_BITS-1:0] merged;
    logic [`LSD_GS_BITS-1:0] next_shift;
    logic [`LSD_GS_BITS-1:0] gs_latch;
    logic status_pending;
    logic tef_clr_pending;
    logic serial_out_q;
    logic [`LSD_STATUS_W-1:0] status_word;

    lsd_phase_t phase;
    lsd_gs_t cnt;
    logic [15:0] open_led_flag;
    logic [15:0] auto_off;
    logic [15:0] raw_on;
    logic [15:0] on_q;
    logic [15:0] delayed;
    logic [15:0] lod_hit;
    logic overtemp_flag;
    logic err;

    logic [`LSD_CTRL_STEP_W-1:0] step;
    logic acc_done;
    logic req;
    logic [31:0] read_mux;

    // Two-stage synchronisers; pin_s1 is read by pin_s2 alone
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pin_s1 <= `LSD_PIN_RST;
            pin_s2 <= `LSD_PIN_RST;
            pin_d <= `LSD_PIN_RST;
        end else if (CE_IN) begin
            pin_s1 <= {OPEN_CMP_IN, OVERTEMP_IN, SERIAL_IN, MODE_IN,
                       OUTPUTS_OFF_IN, LATCH_STROBE_IN, PWM_REF_CLOCK_IN, SERIAL_CLK_IN};
            pin_s2 <= pin_s1;
            pin_d <= pin_s2;
        end
    end

    // Edge events are qualified by the enable so a frozen block counts none twice
    assign sclk_rise = CE_IN & pin_s2[0] & ~pin_d[0];
    assign sclk_fall = CE_IN & ~pin_s2[0] & pin_d[0];
    assign pclk_rise = CE_IN & pin_s2[1] & ~pin_d[1];
    assign pclk_fall = CE_IN & ~pin_s2[1] & pin_d[1];
    assign lat_rise = CE_IN & pin_s2[2] & ~pin_d[2];
    assign lat_fall = CE_IN & ~pin_s2[2] & pin_d[2];
    assign blank = pin_s2[3];
    assign mode = pin_s2[4];
    assign serial_in = pin_s2[5];
    assign overtemp = pin_s2[6];
    assign cmp_low = pin_s2[22:7];

    assign status_word = {overtemp_flag, open_led_flag};

    // Status load only in brightness mode; trim mode shifts plain data
    always_comb begin
        merged = shift_reg;
        if (status_pending && !mode) begin
            merged[`LSD_GS_BITS-1 -: `LSD_STATUS_W] = status_word;
        end
        next_shift = merged;
        if (mode) begin
            next_shift[`LSD_DC_BITS-1:0] = {merged[`LSD_DC_BITS-2:0], serial_in};
        end else begin
            next_shift = {merged[`LSD_GS_BITS-2:0], serial_in};
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            shift_reg <= '0;
            serial_out_q <= 1'b0;
        end else if (CE_IN && sclk_rise) begin
            shift_reg <= next_shift;
            // Top bit leaves before the shift, so the status MSB is not lost
            serial_out_q <= mode ? merged[`LSD_DC_BITS-1] : merged[`LSD_GS_BITS-1];
        end
    end

    // Set by latch fall wins over a clear in the same cycle
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            status_pending <= 1'b0;
        end else if (CE_IN) begin
            if (lat_fall) begin
                status_pending <= 1'b1;
            end else if (sclk_rise) begin
                status_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tef_clr_pending <= 1'b0;
        end else if (CE_IN) begin
            if (lat_fall) begin
                tef_clr_pending <= 1'b1;
            end else if (sclk_fall) begin
                tef_clr_pending <= 1'b0;
            end
        end
    end

    // Data latches, picked by the mode pin
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            gs_latch <= '0;
            CURRENT_TRIM_OUT <= '0;
        end else if (CE_IN && lat_rise) begin
            if (mode) begin
                CURRENT_TRIM_OUT <= shift_reg[`LSD_DC_BITS-1:0];
            end else begin
                gs_latch <= shift_reg;
            end
        end
    end

    // Grayscale phase and counter
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            phase <= PH_BLANK;
            cnt <= '0;
        end else if (CE_IN) begin
            case (phase)
                PH_BLANK: begin
                    cnt <= '0;
                    if (!blank) begin
                        phase <= PH_RUN;
                    end
                end
                PH_RUN: begin
                    if (blank) begin
                        phase <= PH_BLANK;
                        cnt <= '0;
                    end else if (pclk_rise) begin
                        cnt <= cnt + 12'h001;
                        if (cnt + 12'h001 == `LSD_CNT_MAX) begin
                            phase <= PH_HOLD;
                        end
                    end
                end
                PH_HOLD: begin
                    if (blank) begin
                        phase <= PH_BLANK;
                        cnt <= '0;
                    end
                end
                default: begin
                    phase <= PH_BLANK;
                    cnt <= '0;
                end
            endcase
        end
    end

    genvar i;
    generate
        for (i = 0; i < `LSD_CHANNELS; i++) begin : g_ch
            localparam int GRP = i % 4;
            lsd_gs_t gs;
            logic [4:0] tap;
            logic [`LSD_DLY_LEN-1:0] hist;

            assign gs = gs_latch[i*`LSD_GS_W +: `LSD_GS_W];
            // On while the count has not passed the channel's value
            assign raw_on[i] = (phase == PH_RUN) && !blank && (cnt != 12'h000)
                               && (cnt <= gs) && !auto_off[i];
            // Channel is on at the 33rd rise exactly when its value reaches it
            assign lod_hit[i] = (gs >= `LSD_LOD_EDGE) && !auto_off[i] && cmp_low[i];
            assign tap = {2'b00, step} * 5'(GRP);

            always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
                if (!RST_N_IN) begin
                    hist <= '0;
                end else if (CE_IN) begin
                    hist <= {hist[`LSD_DLY_LEN-2:0], on_q[i]};
                end
            end

            // Same delay on both edges keeps each pulse width intact
            assign delayed[i] = (tap == 5'h00) ? on_q[i] : hist[tap - 5'h01];
        end
    endgenerate

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            on_q <= '0;
            SINK_ON_OUT <= '0;
        end else if (CE_IN) begin
            on_q <= raw_on;
            SINK_ON_OUT <= delayed;
        end
    end

    // Open flags: taken on the rise that moves the count to 33
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            open_led_flag <= '0;
        end else if (CE_IN && pclk_rise && phase == PH_RUN && !blank
                     && cnt == `LSD_LOD_EDGE - 12'h001) begin
            open_led_flag <= lod_hit;
        end
    end

    // Switch-off holds until the next blanking, then retries
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            auto_off <= '0;
        end else if (CE_IN) begin
            if (blank) begin
                auto_off <= '0;
            end else if (pclk_fall && phase == PH_RUN && cnt == `LSD_LOD_EDGE) begin
                auto_off <= auto_off | open_led_flag;
            end
        end
    end

    // Overtemp flag: set wins over the clear
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            overtemp_flag <= 1'b0;
        end else if (CE_IN) begin
            if (overtemp) begin
                overtemp_flag <= 1'b1;
            end else if (tef_clr_pending && sclk_fall) begin
                overtemp_flag <= 1'b0;
            end
        end
    end

    assign err = overtemp_flag | ((|open_led_flag) & ~blank);

    // Open-drain: only ever pulls low
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ERROR_OE_OUT <= 1'b0;
        end else if (CE_IN) begin
            ERROR_OE_OUT <= err;
        end
    end

    assign ERROR_OUT_N_OUT = 1'b0;
    assign SERIAL_OUT = serial_out_q;

    // Avalon slave: one wait state on every access
    assign req = AVS_READ_IN | AVS_WRITE_IN;
    assign AVS_WAITREQUEST_OUT = req & ~acc_done;

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            acc_done <= 1'b0;
        end else if (CE_IN) begin
            acc_done <= req & ~acc_done;
        end
    end

    always_comb begin
        case (AVS_ADDRESS_IN)
            `LSD_OFS_CTRL: read_mux = {29'h0, step};
            `LSD_OFS_STATUS: read_mux = {15'h0, status_word};
            `LSD_OFS_PWM: read_mux = {17'h0, phase, cnt};
            `LSD_OFS_PINS: read_mux = {14'h0, mode, blank, auto_off};
            default: read_mux = 32'h0;
        endcase
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            AVS_READDATA_OUT <= 32'h0;
        end else if (CE_IN && AVS_READ_IN && !acc_done) begin
            AVS_READDATA_OUT <= read_mux;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            step <= `LSD_CTRL_STEP_RST;
        end else if (CE_IN && AVS_WRITE_IN && acc_done && AVS_BYTEENABLE_IN[0]
                     && AVS_ADDRESS_IN == `LSD_OFS_CTRL) begin
            step <= AVS_WRITEDATA_IN[`LSD_CTRL_STEP_LSB +: `LSD_CTRL_STEP_W];
        end
    end

endmodule

// [lsd_status_out_props.sv]
`include "lsd_regs.svh"

module lsd_status_out_props (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [5:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic AVS_WAITREQUEST_OUT,
    input wire logic SERIAL_CLK_IN,
    input wire logic LATCH_STROBE_IN,
    input wire logic OUTPUTS_OFF_IN,
    input wire logic OVERTEMP_IN,
    input wire logic SERIAL_OUT,
    input wire logic [15:0] SINK_ON_OUT,
    input wire logic [95:0] CURRENT_TRIM_OUT,
    input wire logic ERROR_OUT_N_OUT,
    input wire logic ERROR_OE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Outputs-off run length; covers sync plus the longest stagger line
    logic [4:0] off_cnt;
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            off_cnt <= 5'h00;
        end else if (!OUTPUTS_OFF_IN) begin
            off_cnt <= 5'h00;
        end else if (off_cnt != 5'h1F) begin
            off_cnt <= off_cnt + 5'h01;
        end
    end
    // Sticky once hot; before that only open flags could pull the line
    logic hot_seen;
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            hot_seen <= 1'b0;
        end else if (OVERTEMP_IN) begin
            hot_seen <= 1'b1;
        end
    end
    a_hot_err_low: assert property (OVERTEMP_IN [*6] |-> ERROR_OE_OUT)
        else $error("error output not pulled while hot");
    a_err_masked: assert property (off_cnt == 5'h1F && !hot_seen |-> !ERROR_OE_OUT)
        else $error("open flags not masked while outputs off");
    a_sink_off_blank: assert property (off_cnt == 5'h1F |-> SINK_ON_OUT == 16'h0000)
        else $error("sink on while outputs off");
    a_trim_hold: assert property (!LATCH_STROBE_IN [*8] |=> $stable(CURRENT_TRIM_OUT))
        else $error("trim latch moved without strobe");
    a_serial_out_hold: assert property (!SERIAL_CLK_IN [*6] |=> $stable(SERIAL_OUT))
        else $error("serial out moved without clock rise");
    a_status_width: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT &&
        AVS_ADDRESS_IN == `LSD_OFS_STATUS |-> AVS_READDATA_OUT[31:17] == 15'h0000)
        else $error("status word wider than 17 bits");
    a_wait_one_state: assert property ($rose(AVS_READ_IN || AVS_WRITE_IN) |->
        AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
        else $error("waitrequest not one cycle");
    a_unmapped_zero: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT &&
        AVS_ADDRESS_IN >= 6'h10 |-> AVS_READDATA_OUT == 32'h00000000)
        else $error("unmapped read not zero");
endmodule

bind lsd_status_out lsd_status_out_props u_props (.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN),
    .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
    .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
    .SERIAL_CLK_IN(SERIAL_CLK_IN), .LATCH_STROBE_IN(LATCH_STROBE_IN),
    .OUTPUTS_OFF_IN(OUTPUTS_OFF_IN), .OVERTEMP_IN(OVERTEMP_IN), .SERIAL_OUT(SERIAL_OUT),
    .SINK_ON_OUT(SINK_ON_OUT), .CURRENT_TRIM_OUT(CURRENT_TRIM_OUT),
    .ERROR_OUT_N_OUT(ERROR_OUT_N_OUT), .ERROR_OE_OUT(ERROR_OE_OUT));

// [lsd_tb.sv]
`include "lsd_regs.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic sclk, sdata, latch, mode, serial_out, err_n, err_oe;
    logic off = 1'b1;
    logic pwm = 1'b0;
    logic hot = 1'b0;
    logic [15:0] cmp = 16'h0000;
    logic [15:0] sink;
    logic [95:0] trim;
    logic err_wire;
    int n_mismatch = 0;
    int compares = 0;
    assign err_wire = err_oe ? err_n : 1'b1;
    always #12.5 clk = ~clk;
    lsd_status_out u_lsd_status_out (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(1'b1),
        .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
        .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
        .SERIAL_CLK_IN(sclk), .LATCH_STROBE_IN(latch), .SERIAL_IN(sdata), .MODE_IN(mode),
        .OUTPUTS_OFF_IN(off), .PWM_REF_CLOCK_IN(pwm), .OPEN_CMP_IN(cmp), .OVERTEMP_IN(hot),
        .SERIAL_OUT(serial_out), .SINK_ON_OUT(sink), .CURRENT_TRIM_OUT(trim),
        .ERROR_OUT_N_OUT(err_n), .ERROR_OE_OUT(err_oe));
    lsd_host_model u_lsd_host_model (.clk_in(clk), .serial_out_in(serial_out), .sclk_out(sclk),
        .sdata_out(sdata), .latch_out(latch), .mode_out(mode));
    task automatic check(input logic [191:0] got, input logic [191:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic av(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        // No local limit; a hung slave is caught by the watchdog
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic pwm_pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            pwm <= 1'b1;
            repeat (4) @(posedge clk);
            pwm <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (30) @(posedge clk);
    endtask
    task automatic t_regs();
        logic [31:0] r;
        av(1'b0, `LSD_OFS_CTRL, 32'h0, r);
        check(r, {29'h0, `LSD_CTRL_STEP_RST});
        av(1'b1, `LSD_OFS_CTRL, 32'h00000005, r);
        av(1'b0, `LSD_OFS_CTRL, 32'h0, r);
        check(r, 32'h00000005);
        av(1'b1, 6'h10, 32'hFFFFFFFF, r);
        av(1'b0, 6'h10, 32'h0, r);
        check(r, 32'h00000000);
        av(1'b1, `LSD_OFS_STATUS, 32'hFFFFFFFF, r);
        av(1'b0, `LSD_OFS_STATUS, 32'h0, r);
        check(r, 32'h00000000);
        av(1'b1, `LSD_OFS_CTRL, 32'h00000001, r);
        $display("t_regs done");
    endtask
    task automatic t_open();
        logic [191:0] d, g;
        logic [31:0] r;
        for (int c = 0; c < 16; c++) begin
            d[12*c +: 12] = (c == 1) ? 12'h010 : 12'h030; // Channel 1 below 21h
        end
        u_lsd_host_model.send(d, 192, g);
        u_lsd_host_model.pulse();
        cmp <= 16'h0003;
        off <= 1'b0;
        pwm_pulses(40);
        av(1'b0, `LSD_OFS_STATUS, 32'h0, r);
        check(r, 32'h00000001);
        check(sink, 16'hFFFC);
        check(err_wire, 1'b0);
        av(1'b0, `LSD_OFS_PINS, 32'h0, r);
        check(r, 32'h00000001);
        av(1'b0, `LSD_OFS_PWM, 32'h0, r);
        check(r, 32'h00002028);
        off <= 1'b1;
        repeat (40) @(posedge clk);
        check(sink, 16'h0000);
        check(err_wire, 1'b1);
        av(1'b0, `LSD_OFS_PWM, 32'h0, r);
        check(r, 32'h00001000);
        u_lsd_host_model.send({d[191:12], 12'h000}, 192, g);
        check(g, {17'h00001, d[174:0]});
        u_lsd_host_model.pulse();
        cmp <= 16'h0000;
        $display("t_open done");
    endtask
    task automatic t_hot();
        logic [191:0] g;
        logic [31:0] r;
        hot <= 1'b1;
        repeat (8) @(posedge clk);
        check(err_wire, 1'b0);
        av(1'b0, `LSD_OFS_STATUS, 32'h0, r);
        check(r, 32'h00010001);
        hot <= 1'b0;
        repeat (8) @(posedge clk);
        check(err_wire, 1'b0);
        u_lsd_host_model.pulse();
        u_lsd_host_model.send(192'h0, 17, g);
        check(g[16:0], 17'h10001);
        av(1'b0, `LSD_OFS_STATUS, 32'h0, r);
        check(r, 32'h00000001);
        repeat (4) @(posedge clk);
        check(err_wire, 1'b1);
        $display("t_hot done");
    endtask
    task automatic t_trim();
        logic [191:0] g;
        u_lsd_host_model.set_mode(1'b1);
        u_lsd_host_model.send({96'h0, 96'hF0E1D2C3B4A5968778695A4B}, 96, g);
        u_lsd_host_model.pulse();
        check(trim, 96'hF0E1D2C3B4A5968778695A4B);
        u_lsd_host_model.set_mode(1'b0);
        $display("t_trim done");
    endtask
    task automatic test_done();
        $display("Counts: compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_open();
        t_hot();
        t_trim();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule
